// File: rtl/scd_pkg.sv
// package: constants, field layouts and types of the stepper chop/decay sequencer
// Functional notes
// - two decay select bits pick mixed, slow only, fast only or adaptive decay.
// - a new decay selection takes effect only from the next chopping cycle.
// - mixed cycle is 16 oscillator clocks; fast decay fixed at 6; slow fills rest.
// - charge ends when current-limit detection asserts; earlier detection means longer slow.
// - mixed: without limit detection charge carries into following cycles until it asserts.
// - adaptive mode regulates using supply current and regenerated current detection.
// - adaptive threshold inside blanking waits for blanking end before slow decay.
// - adaptive: long charge continues into next cycle until current-limit detection.
// - while reset input is high the electrical angle holds its initial state.
// - in reset currents are 100% (full, half a) else 71%, angle 45 degrees.
package scd_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] SCD_OFS_CTRL = 8'h00;
  localparam logic [7:0] SCD_OFS_STATUS = 8'h04;
  localparam logic [7:0] SCD_OFS_CURR = 8'h08;
  localparam logic [7:0] SCD_CTRL_RST = 8'h08;

  // status and current field positions
  localparam int SCD_ST_PHASE_LSB = 0;
  localparam int SCD_ST_MODE_LSB = 2;
  localparam int SCD_ST_LIMIT_BIT = 4;
  localparam int SCD_ST_ADAPT_BIT = 5;
  localparam int SCD_ST_ANGLE_LSB = 8;
  localparam int SCD_ST_CYCLE_LSB = 16;
  localparam int SCD_CURR_B_LSB = 8;

  // ****************************************
  // timing, angle and current constants
  // ****************************************
  localparam logic [3:0] SCD_CHOP_LAST = 4'hF;
  localparam logic [3:0] SCD_FAST_CLKS = 4'h6;
  localparam int SCD_BLANK_CLKS_DFLT = 2;
  localparam int SCD_OSC_DIV_DFLT = 4;
  localparam logic [6:0] SCD_ANGLE_INIT = 7'h10;
  localparam logic [7:0] SCD_CUR_FULL = 8'h64;
  localparam logic [7:0] SCD_CUR_MICRO = 8'h47;

  // step resolution codes
  localparam logic [2:0] SCD_RES_FULL = 3'h0;
  localparam logic [2:0] SCD_RES_HALF_A = 3'h1;
  localparam logic [2:0] SCD_RES_HALF_B = 3'h2;
  localparam logic [2:0] SCD_RES_QUARTER = 3'h3;
  localparam logic [2:0] SCD_RES_EIGHTH = 3'h4;
  localparam logic [2:0] SCD_RES_SIXTEENTH = 3'h5;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {PH_SLOW, PH_CHARGE, PH_FAST} scd_phase_t;
  typedef enum logic [1:0] {MD_MIXED, MD_SLOW, MD_FAST, MD_ADAPT} scd_mode_t;

  typedef struct packed {
    logic step_dir;
    logic [2:0] step_res;
    logic angle_rst;
    logic chop_en;
    logic decay_sel_hi;
    logic decay_sel_lo;
  } scd_ctrl_t;

  typedef struct packed {
    scd_phase_t phase;
    scd_mode_t mode;
    logic [3:0] cycle;
  } scd_chop_t;

endpackage

// File: rtl/scd_sync.sv
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module scd_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  import scd_pkg::*;

  if (WIDTH < 1) begin : g_width_chk
    $error("scd_sync: WIDTH must be at least 1");
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // the first stage feeds only the second
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          level_o[g] <= 1'b0;
        end else begin
          s1 <= pin_i[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            level_o[g] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule // scd_sync
`default_nettype wire

// File: rtl/scd_osc_div.sv
// module: divider producing the chopping oscillator enable pulse
`timescale 1ns/100ps
`default_nettype none
module scd_osc_div #(
  parameter int DIV = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // one-cycle oscillator tick
  output logic tick_o
);
  import scd_pkg::*;

  if (DIV < 1 || DIV > 65536) begin : g_div_chk
    $error("scd_osc_div: DIV out of range");
  end

  logic [15:0] cnt;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt == 16'(DIV - 1)) begin
      cnt <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule // scd_osc_div
`default_nettype wire

// File: rtl/scd_chop_ctrl.sv
// module: chopping sequencer with decay selection, angle reset and APB registers
`timescale 1ns/100ps
`default_nettype none
module scd_chop_ctrl #(
  parameter int OSC_DIV = scd_pkg::SCD_OSC_DIV_DFLT,
  parameter int BLANK_CLKS = scd_pkg::SCD_BLANK_CLKS_DFLT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // comparator and step pins
  input wire logic current_limit_reached_i,
  input wire logic adaptive_current_threshold_i,
  input wire logic step_i,
  // power stage and angle outputs
  output scd_pkg::scd_chop_t chop_o,
  output logic [6:0] angle_o,
  output logic angle_init_o,
  output logic [7:0] cur_a_o,
  output logic [7:0] cur_b_o
);
  import scd_pkg::*;

  if (BLANK_CLKS < 1 || BLANK_CLKS > 15) begin : g_blank_chk
    $error("scd_chop_ctrl: BLANK_CLKS out of range");
  end

  localparam logic [3:0] BLANK_LAST = 4'(BLANK_CLKS);

  // ****************************************
  // pin synchronisers and oscillator
  // ****************************************
  logic [2:0] pins_s;
  logic limit_s;
  logic adapt_s;
  logic step_s;
  logic step_d;
  logic tick;

  scd_sync #(.WIDTH(3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({step_i, adaptive_current_threshold_i, current_limit_reached_i}),
    .level_o(pins_s)
  );

  scd_osc_div #(.DIV(OSC_DIV)) u_osc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  assign limit_s = pins_s[0];
  assign adapt_s = pins_s[1];
  assign step_s = pins_s[2];

  // ****************************************
  // apb register file
  // ****************************************
  scd_ctrl_t ctrl;
  logic wr_en;
  logic mapped;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  logic [31:0] curr_word;

  assign pready_o = 1'b1;
  assign mapped = (paddr_i == SCD_OFS_CTRL) || (paddr_i == SCD_OFS_STATUS)
                  || (paddr_i == SCD_OFS_CURR);
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign wr_en = psel_i && penable_i && pwrite_i && (paddr_i == SCD_OFS_CTRL);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= scd_ctrl_t'(SCD_CTRL_RST);
    end else if (wr_en) begin
      ctrl <= scd_ctrl_t'(pwdata_i[7:0]);
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[SCD_ST_PHASE_LSB +: 2] = chop_o.phase;
    status_word[SCD_ST_MODE_LSB +: 2] = chop_o.mode;
    status_word[SCD_ST_LIMIT_BIT] = limit_s;
    status_word[SCD_ST_ADAPT_BIT] = adapt_s;
    status_word[SCD_ST_ANGLE_LSB +: 7] = angle_o;
    status_word[SCD_ST_CYCLE_LSB +: 4] = chop_o.cycle;
    curr_word = 32'h0000_0000;
    curr_word[7:0] = cur_a_o;
    curr_word[SCD_CURR_B_LSB +: 8] = cur_b_o;
  end

  always_comb begin
    if (paddr_i == SCD_OFS_CTRL) begin
      next_rdata = {24'h00_0000, ctrl};
    end else if (paddr_i == SCD_OFS_STATUS) begin
      next_rdata = status_word;
    end else if (paddr_i == SCD_OFS_CURR) begin
      next_rdata = curr_word;
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // read data is caught in the setup cycle so the access phase needs no wait
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= next_rdata;
    end
  end

  // ****************************************
  // chopping sequencer
  // ****************************************
  scd_mode_t sel_mode;
  logic wrap;
  logic [3:0] fast_cnt;
  logic [3:0] blank_cnt;
  logic blank_done;
  logic thr_seen;

  always_comb begin
    case ({ctrl.decay_sel_hi, ctrl.decay_sel_lo})
      2'b00: sel_mode = MD_MIXED;
      2'b01: sel_mode = MD_SLOW;
      2'b10: sel_mode = MD_FAST;
      default: sel_mode = MD_ADAPT;
    endcase
  end

  assign wrap = tick && (chop_o.cycle == SCD_CHOP_LAST);
  assign blank_done = (blank_cnt == BLANK_LAST);

  // cycle counter wraps every 16 oscillator clocks
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chop_o.cycle <= 4'h0;
    end else if (!ctrl.chop_en) begin
      chop_o.cycle <= 4'h0;
    end else if (tick) begin
      chop_o.cycle <= chop_o.cycle + 4'h1;
    end
  end

  // with chopping enabled, a changed selection is held off until the cycle boundary
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chop_o.mode <= MD_MIXED;
    end else if (!ctrl.chop_en) begin
      chop_o.mode <= sel_mode;
    end else if (wrap) begin
      chop_o.mode <= sel_mode;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chop_o.phase <= PH_SLOW;
      fast_cnt <= 4'h0;
      blank_cnt <= 4'h0;
      thr_seen <= 1'b0;
    end else if (!ctrl.chop_en) begin
      chop_o.phase <= PH_SLOW;
      fast_cnt <= 4'h0;
      blank_cnt <= 4'h0;
      thr_seen <= 1'b0;
    end else if (wrap) begin
      // every cycle opens with charge; an unfinished charge simply carries on
      chop_o.phase <= PH_CHARGE;
      fast_cnt <= 4'h0;
      blank_cnt <= 4'h0;
      thr_seen <= 1'b0;
    end else if (tick) begin
      case (chop_o.phase)
        PH_CHARGE: begin
          if (limit_s) begin
            if (chop_o.mode == MD_SLOW) begin
              chop_o.phase <= PH_SLOW;
            end else begin
              chop_o.phase <= PH_FAST;
            end
          end
          fast_cnt <= 4'h0;
          blank_cnt <= 4'h0;
          thr_seen <= 1'b0;
        end
        PH_FAST: begin
          if (chop_o.mode == MD_MIXED) begin
            if (fast_cnt == SCD_FAST_CLKS - 4'h1) begin
              chop_o.phase <= PH_SLOW;
            end else begin
              fast_cnt <= fast_cnt + 4'h1;
            end
          end else if (chop_o.mode == MD_ADAPT) begin
            // regenerated current falls to the threshold; a threshold seen inside the
            // blanking window is kept in thr_seen and acted on once blanking ends
            if (!blank_done) begin
              blank_cnt <= blank_cnt + 4'h1;
              thr_seen <= thr_seen || adapt_s;
            end else if (adapt_s || thr_seen) begin
              chop_o.phase <= PH_SLOW;
            end
          end
        end
        default: begin
          chop_o.phase <= PH_SLOW;
        end
      endcase
    end
  end

  // ****************************************
  // electrical angle
  // ****************************************
  logic [6:0] step_inc;
  logic step_rise;

  assign step_rise = step_s && !step_d;

  always_comb begin
    case (ctrl.step_res)
      SCD_RES_FULL: step_inc = 7'h20;
      SCD_RES_HALF_A: step_inc = 7'h10;
      SCD_RES_HALF_B: step_inc = 7'h10;
      SCD_RES_QUARTER: step_inc = 7'h08;
      SCD_RES_EIGHTH: step_inc = 7'h04;
      SCD_RES_SIXTEENTH: step_inc = 7'h02;
      default: step_inc = 7'h01;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_d <= 1'b0;
    end else begin
      step_d <= step_s;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      angle_o <= SCD_ANGLE_INIT;
    end else if (ctrl.angle_rst) begin
      angle_o <= SCD_ANGLE_INIT;
    end else if (step_rise && ctrl.step_dir) begin
      angle_o <= angle_o - step_inc;
    end else if (step_rise) begin
      angle_o <= angle_o + step_inc;
    end
  end

  assign angle_init_o = (angle_o == SCD_ANGLE_INIT);

  // the per-angle current table lives outside; only the reset values are set here
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_a_o <= SCD_CUR_FULL;
      cur_b_o <= SCD_CUR_FULL;
    end else if (ctrl.angle_rst) begin
      if (ctrl.step_res == SCD_RES_FULL || ctrl.step_res == SCD_RES_HALF_A) begin
        cur_a_o <= SCD_CUR_FULL;
        cur_b_o <= SCD_CUR_FULL;
      end else begin
        cur_a_o <= SCD_CUR_MICRO;
        cur_b_o <= SCD_CUR_MICRO;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_sel_decode;
    @(posedge clk_i) disable iff (rst_i)
    (wrap && ctrl.chop_en && !wr_en && ctrl.decay_sel_hi && ctrl.decay_sel_lo)
      |=> (chop_o.mode == MD_ADAPT);
  endproperty
  a_sel_decode: assert property (p_sel_decode) else $error("adaptive not chosen");

  property p_mode_hold;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl.chop_en && !wrap) ##1 ctrl.chop_en |-> $stable(chop_o.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid cycle");

  property p_fast_len;
    @(posedge clk_i) disable iff (rst_i)
    (chop_o.phase == PH_FAST && chop_o.mode == MD_MIXED && tick && !wrap
     && fast_cnt == 4'h5 && ctrl.chop_en) |=> (chop_o.phase == PH_SLOW) || !ctrl.chop_en;
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("fast decay not 6 clocks");

  property p_charge_end;
    @(posedge clk_i) disable iff (rst_i)
    (chop_o.phase == PH_CHARGE && limit_s && tick && !wrap && ctrl.chop_en)
      |=> (chop_o.phase != PH_CHARGE);
  endproperty
  a_charge_end: assert property (p_charge_end) else $error("charge ignored limit");

  property p_charge_hold;
    @(posedge clk_i) disable iff (rst_i)
    (chop_o.phase == PH_CHARGE && !limit_s && ctrl.chop_en)
      |=> (chop_o.phase == PH_CHARGE) || !ctrl.chop_en;
  endproperty
  a_charge_hold: assert property (p_charge_hold) else $error("charge left early");

  property p_adapt_slow;
    @(posedge clk_i) disable iff (rst_i)
    (chop_o.phase == PH_FAST && chop_o.mode == MD_ADAPT && adapt_s && blank_done
     && tick && !wrap && ctrl.chop_en) |=> (chop_o.phase == PH_SLOW) || !ctrl.chop_en;
  endproperty
  a_adapt_slow: assert property (p_adapt_slow) else $error("adaptive slow missed");

  property p_blank_wait;
    @(posedge clk_i) disable iff (rst_i)
    (chop_o.phase == PH_FAST && chop_o.mode == MD_ADAPT && !blank_done)
      |=> (chop_o.phase != PH_SLOW) || !ctrl.chop_en;
  endproperty
  a_blank_wait: assert property (p_blank_wait) else $error("slow inside blanking");

  property p_angle_rst;
    @(posedge clk_i) disable iff (rst_i)
    ctrl.angle_rst ##1 ctrl.angle_rst |-> angle_init_o;
  endproperty
  a_angle_rst: assert property (p_angle_rst) else $error("angle moved in reset");

  property p_rst_current;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl.angle_rst && ctrl.step_res == SCD_RES_QUARTER && !wr_en)
      |=> (cur_a_o == SCD_CUR_MICRO) && (cur_b_o == SCD_CUR_MICRO);
  endproperty
  a_rst_current: assert property (p_rst_current) else $error("reset current wrong");

  property p_wrap;
    @(posedge clk_i) disable iff (rst_i)
    (wrap && ctrl.chop_en && !wr_en) |=> (chop_o.cycle == 4'h0) && (chop_o.phase == PH_CHARGE);
  endproperty
  a_wrap: assert property (p_wrap) else $error("cycle did not restart");

  c_mixed_slow: cover property (@(posedge clk_i) disable iff (rst_i)
    chop_o.mode == MD_MIXED && chop_o.phase == PH_FAST ##1 chop_o.phase == PH_SLOW);
  c_long_charge: cover property (@(posedge clk_i) disable iff (rst_i)
    wrap && chop_o.phase == PH_CHARGE && !limit_s);
  c_adapt_blank: cover property (@(posedge clk_i) disable iff (rst_i)
    chop_o.mode == MD_ADAPT && thr_seen && blank_done);

endmodule // scd_chop_ctrl
`default_nettype wire

// File: verification/scd_winding_model.sv
// partner model: winding current seen by the comparator pins
`timescale 1ns/100ps
`default_nettype none
module scd_winding_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // chopper state and winding set-up
  input wire scd_pkg::scd_chop_t chop_i,
  input wire logic [7:0] charge_clks_i,
  input wire logic [7:0] thr_clks_i,
  // comparator pins
  output logic limit_o,
  output logic thr_o
);
  import scd_pkg::*;
  logic [7:0] cnt;
  scd_phase_t prev;
  // ****************************************
  // time spent in the present phase
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
      prev <= PH_SLOW;
    end else begin
      prev <= chop_i.phase;
      if (chop_i.phase != prev) begin
        cnt <= 8'h00;
      end else if (cnt != 8'hFF) begin
        cnt <= cnt + 8'h01;
      end
    end
  end
  // ****************************************
  // comparators
  // ****************************************
  // current only rises while charging, so decay never reports the limit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      limit_o <= 1'b0;
      thr_o <= 1'b0;
    end else begin
      // on the first clock of a phase cnt still holds the old phase's time
      limit_o <= (chop_i.phase == PH_CHARGE) && (prev == PH_CHARGE) && (cnt >= charge_clks_i);
      thr_o <= (chop_i.phase == PH_FAST) && (prev == PH_FAST) && (cnt >= thr_clks_i);
    end
  end
endmodule // scd_winding_model
`default_nettype wire

// File: verification/test_scd_chop_ctrl.sv
// testbench: register, stepping and decay sequencing checks of the chop sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module test_scd_chop_ctrl;
  import scd_pkg::*;
  localparam int OSC = 4;
  localparam int BLK = 2;
  logic clk_i, rst_i, psel, penable, pwrite, step_i, limit, thr, pready_o, pslverr_o;
  logic [7:0] paddr, chg_clks, thr_clks, cur_a_o, cur_b_o;
  logic [31:0] pwdata, prdata_o, rv;
  logic [6:0] angle_o;
  logic angle_init_o, er;
  scd_chop_t chop_o;
  int miscompares = 0;
  int tests_run = 0;
  int c1, f1, s1, c2, f2, s2;
  int stp[8] = '{32, 16, 16, 8, 4, 2, 1, 1};
  scd_chop_ctrl #(.OSC_DIV(OSC), .BLANK_CLKS(BLK)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .current_limit_reached_i(limit), .adaptive_current_threshold_i(thr), .step_i(step_i),
    .chop_o(chop_o), .angle_o(angle_o), .angle_init_o(angle_init_o), .cur_a_o(cur_a_o),
    .cur_b_o(cur_b_o));
  scd_winding_model u_wind (.clk_i(clk_i), .rst_i(rst_i), .chop_i(chop_o),
    .charge_clks_i(chg_clks), .thr_clks_i(thr_clks), .limit_o(limit), .thr_o(thr));
  // ****************************************
  // bus and timing tasks
  // ****************************************
  // starts on an edge, so two calls in a row leave one idle edge between them
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rv = prdata_o;
    er = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  function automatic logic [31:0] ctl(logic d, logic [2:0] r, logic a, logic e, logic [1:0] s);
    scd_ctrl_t c;
    c = '{step_dir: d, step_res: r, angle_rst: a, chop_en: e, decay_sel_hi: s[1],
      decay_sel_lo: s[0]};
    return {24'h0, c};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_cyc(input logic [3:0] c);
    int w;
    w = 0;
    while (chop_o.cycle !== c && w < 400) begin
      tick(1);
      w++;
    end
    if (w >= 400) miscompares++;
  endtask
  // time spent in a phase from now on; zero if the phase is not present
  task automatic dur(input scd_phase_t ph, output int n);
    n = 0;
    while (chop_o.phase === ph && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) miscompares++;
  endtask
  // drain the cycle in progress, then measure one that opens with a fresh charge
  task automatic run(input logic [7:0] cc, output int c, output int f, output int s);
    chg_clks <= cc;
    dur(PH_CHARGE, c);
    dur(PH_FAST, f);
    dur(PH_SLOW, s);
    dur(PH_CHARGE, c);
    dur(PH_FAST, f);
    dur(PH_SLOW, s);
  endtask
  task automatic pulse;
    @(posedge clk_i);
    step_i <= 1'b1;
    tick(12);
    @(posedge clk_i);
    step_i <= 1'b0;
    tick(12);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****************************************
  // clock, watchdog and tests
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    wrap_up;
  end
  initial begin
    rst_i = 1'b1;
    {psel, penable, pwrite, step_i} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chg_clks = 8'h04;
    thr_clks = 8'h00;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    apb(1'b0, SCD_OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h8, rv)
    `CHK("mapped err", 1'b0, er)
    apb(1'b0, SCD_OFS_STATUS, 32'h0);
    `CHK("angle reset", 7'h10, rv[14:8])
    `CHK("angle init", 1'b1, angle_init_o)
    apb(1'b1, SCD_OFS_CURR, 32'h0);
    apb(1'b0, SCD_OFS_CURR, 32'h0);
    `CHK("curr reset", 32'h6464, rv)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rv)
    $display("test registers done");
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, SCD_OFS_CTRL, ctl(1'b0, 3'(r), 1'b1, 1'b0, 2'b00));
      pulse;
      `CHK("held angle", 7'h10, angle_o)
      `CHK("cur a", (r < 2) ? 8'h64 : 8'h47, cur_a_o)
      `CHK("cur b", (r < 2) ? 8'h64 : 8'h47, cur_b_o)
      for (int d = 0; d < 2; d++) begin
        apb(1'b1, SCD_OFS_CTRL, ctl(1'(d), 3'(r), 1'b0, 1'b0, 2'b00));
        pulse;
        `CHK("step angle", (d == 0) ? 7'(16 + stp[r]) : 7'h10, angle_o)
        `CHK("init flag", 1'(d), angle_init_o)
      end
    end
    $display("test stepping done");
    apb(1'b1, SCD_OFS_CTRL, ctl(1'b0, 3'h0, 1'b1, 1'b1, 2'b00));
    run(8'h04, c1, f1, s1);
    `CHK("mixed fast", 6 * OSC, f1)
    `CHK("cycle length", 16 * OSC, c1 + f1 + s1)
    run(8'h14, c2, f2, s2);
    `CHK("later limit", 1'b1, (s2 < s1) && (c2 > c1) && (f2 == 6 * OSC))
    run(8'h50, c2, f2, s2);
    `CHK("long charge", 1'b1, c2 > 16 * OSC)
    `CHK("fast after", 6 * OSC, f2)
    $display("test mixed done");
    run(8'h04, c1, f1, s1);
    wait_cyc(4'h4);
    apb(1'b1, SCD_OFS_CTRL, ctl(1'b0, 3'h0, 1'b1, 1'b1, 2'b10));
    `CHK("mode kept", MD_MIXED, chop_o.mode)
    wait_cyc(4'hF);
    `CHK("mode at end", MD_MIXED, chop_o.mode)
    wait_cyc(4'h0);
    `CHK("mode fast", MD_FAST, chop_o.mode)
    wait_cyc(4'hF);
    `CHK("fast only", PH_FAST, chop_o.phase)
    apb(1'b1, SCD_OFS_CTRL, ctl(1'b0, 3'h0, 1'b1, 1'b1, 2'b01));
    run(8'h04, c1, f1, s1);
    `CHK("mode slow", MD_SLOW, chop_o.mode)
    `CHK("slow only", 16 * OSC, c1 + s1)
    $display("test modes done");
    thr_clks <= 8'h00;
    apb(1'b1, SCD_OFS_CTRL, ctl(1'b0, 3'h0, 1'b1, 1'b1, 2'b11));
    run(8'h04, c1, f1, s1);
    `CHK("mode adapt", MD_ADAPT, chop_o.mode)
    `CHK("blank wait", (BLK + 1) * OSC, f1)
    thr_clks <= 8'h14;
    run(8'h04, c1, f1, s1);
    `CHK("regen fast", 1'b1, (f1 > BLK * OSC) && (s1 > 0))
    run(8'h64, c2, f2, s2);
    `CHK("adapt charge", 1'b1, (c2 > 16 * OSC) && (f2 > 0))
    $display("test adaptive done");
    wrap_up;
  end
endmodule // test_scd_chop_ctrl
`default_nettype wire
